// ==== bvs_consts.svh ====
`ifndef BVS_CONSTS_SVH
`define BVS_CONSTS_SVH
// register offsets on the i2c target port
`define BVS_OFS_CPU_BASE      8'h10
`define BVS_OFS_SOC_BASE      8'h11
`define BVS_OFS_RAIL_CTRL     8'h12
`define BVS_OFS_CPU_TARGET    8'h13
`define BVS_OFS_SOC_TARGET    8'h14
`define BVS_OFS_HALF2_BASE    8'h15
`define BVS_OFS_TRK_VOLT      8'h18
`define BVS_OFS_TRK_CTRL      8'h19
`define BVS_OFS_DEV_CFG       8'h7f
// rail control bits
`define BVS_RC_CPU_ON         0
`define BVS_RC_SOC_ON         1
`define BVS_RC_CPU_SCALE      2
`define BVS_RC_SOC_SCALE      3
`define BVS_RC_HALF2_ON       4
`define BVS_RC_EXT_EN         5
// device configuration bits
`define BVS_CFG_SPLIT         0
`define BVS_CFG_TRK_SRC       1
// tracking control bits
`define BVS_TC_FOLLOW         0
// reset values
`define BVS_RST_BYTE          8'h00
// frame and timing figures
`define BVS_FRAME_PERIODS     6'd32
`define BVS_STEP_UV           12500
`define BVS_LINK_MIN_HZ       3000000
`define BVS_LINK_MAX_HZ       33000000
`define BVS_I2C_HS_HZ         3400000
`endif

// ==== bvs_pkg.sv ====
package bvs_pkg;
   typedef enum logic [3:0] {
      BVS_I_IDLE    = 4'b0000,
      BVS_I_ADDR    = 4'b0001,
      BVS_I_ACK_ADR = 4'b0010,
      BVS_I_REG     = 4'b0011,
      BVS_I_ACK_REG = 4'b0100,
      BVS_I_WRITE   = 4'b0101,
      BVS_I_ACK_WR  = 4'b0110,
      BVS_I_READ    = 4'b0111,
      BVS_I_RD_ACK  = 4'b1000
   } bvs_i2c_state_t;

   typedef struct packed {
      logic       done;
      logic [5:0] offset;
   } bvs_frame_t;
endpackage

// ==== bvs_frame_decoder.sv ====
`timescale 1ns/10ps
`include "bvs_consts.svh"
module bvs_frame_decoder (
   input  wire logic        i_clk_sys, // system clock
   input  wire logic        i_reset,   // sync reset, high
   input  wire logic        i_enable,  // serial scaling enabled
   input  wire logic        i_link_clk, // scaling clock pin
   input  wire logic        i_data,    // scaling data pin
   output bvs_pkg::bvs_frame_t o_frame // decoded frame
);
   logic [2:0] clk_sync_r;
   logic [2:0] dat_sync_r;
   logic       clk_lvl_r;
   logic       dat_lvl_r;
   logic       in_frame_r;
   logic [5:0] period_cnt_r;
   logic [5:0] high_cnt_r;
   bvs_pkg::bvs_frame_t frame_r;
   logic       clk_rise;
   logic       dat_rise;

   // three-flop synchronisers, level moves once stages two and three agree
   always_ff @(posedge i_clk_sys)
   begin
      if (i_reset)
      begin
         clk_sync_r <= 3'h0;
         dat_sync_r <= 3'h0;
         clk_lvl_r  <= 1'b0;
         dat_lvl_r  <= 1'b0;
      end
      else
      begin
         clk_sync_r <= {clk_sync_r[1:0], i_link_clk};
         dat_sync_r <= {dat_sync_r[1:0], i_data};
         if (clk_sync_r[1] == clk_sync_r[2])
            clk_lvl_r <= clk_sync_r[2];
         if (dat_sync_r[1] == dat_sync_r[2])
            dat_lvl_r <= dat_sync_r[2];
      end
   end

   // edges seen on the filtered levels, any duty cycle or rate that holds each level for at least two system clocks [R6]
   assign clk_rise = (clk_sync_r[1] == clk_sync_r[2]) & clk_sync_r[2] & ~clk_lvl_r;
   assign dat_rise = (dat_sync_r[1] == dat_sync_r[2]) & dat_sync_r[2] & ~dat_lvl_r;

   // frame collector: data rising edge opens, 32 clock periods sampled
   always_ff @(posedge i_clk_sys)
   begin
      if (i_reset || !i_enable)
      begin
         in_frame_r   <= 1'b0;
         period_cnt_r <= 6'h00;
         high_cnt_r   <= 6'h00;
         frame_r      <= '0;
      end
      else
      begin
         frame_r.done <= 1'b0;
         if (!in_frame_r)
         begin
            if (dat_rise) // frame start marker [R5]
            begin
               in_frame_r   <= 1'b1;
               period_cnt_r <= 6'h00;
               high_cnt_r   <= 6'h00;
            end
         end
         else if (clk_rise)
         begin
            period_cnt_r <= period_cnt_r + 6'h01; // [R4]
            if (period_cnt_r == `BVS_FRAME_PERIODS - 6'h01)
            begin
               in_frame_r     <= 1'b0;
               frame_r.done   <= 1'b1;
               frame_r.offset <= high_cnt_r + {5'h00, dat_lvl_r}; // [R16]
            end
            else
               high_cnt_r <= high_cnt_r + {5'h00, dat_lvl_r};
         end
      end
   end

   assign o_frame = frame_r;
endmodule

// ==== bvs_scaling_control.sv ====
`timescale 1ns/10ps
`include "bvs_consts.svh"
// Functional notes
// R1: frame offset steps added to base voltage
// R2: base voltage comes from per-rail register
// R3: driver keeps scaling clock 3 to 33MHz
// R4: sample data over 32 clock periods
// R5: data rising edge marks frame start
// R6: decode independent of rate and duty
// R7: rail off clears its scaling enable
// R8: split bit divides cpu buck in two
// R9: split moves power-good pins' roles
// R10: split: only first half scales
// R11: follow bit makes tracking regulator follow buck
// R12: source bit: 0 soc, 1 cpu
// R13: otherwise tracking voltage from its register
// R14: registers reached through i2c target port
// R15: scaling active only while enable set
// R16: offset counts high samples, applied at end
module bvs_scaling_control #(
   parameter logic [6:0] DEV_ADDR = 7'h2a // arbitrary neutral bus address
) (
   input  wire logic       i_clk_sys,     // 200 MHz system clock
   input  wire logic       i_reset,       // sync reset, high
   input  wire logic       i_scl,         // i2c clock pin
   input  wire logic       i_sda,         // i2c data pin in
   output logic            o_sda_out,     // i2c data drive value
   output logic            o_sda_oe,      // i2c data drive enable
   input  wire logic       i_cpu_scl_clk, // cpu scaling clock pin
   input  wire logic       i_cpu_scaling_serial_data, // cpu scaling data pin
   input  wire logic       i_soc_scl_clk, // soc scaling clock pin
   input  wire logic       i_soc_scaling_serial_data, // soc scaling data pin
   input  wire logic       i_cpu_power_good, // cpu rail power good
   output logic [7:0]      o_cpu_target,  // cpu or first half target code
   output logic [7:0]      o_soc_target,  // soc target code
   output logic [7:0]      o_half2_target, // second half target code
   output logic            o_cpu_on,      // cpu rail enable
   output logic            o_soc_on,      // soc rail enable
   output logic            o_half2_on,    // second half enable
   output logic            o_split,       // cpu buck split mode
   output logic            o_pg_pin_out,  // first power-good pin value
   output logic            o_pg_pin_oe,   // first power-good pin drive
   output logic            o_ext_pin_out, // ext enable / second pg pin
   output logic            o_trk_follow,  // tracking regulator follows buck
   output logic [7:0]      o_trk_target   // tracking regulator code
);
   logic [2:0] scl_sync_r;
   logic [2:0] sda_sync_r;
   logic       scl_r;
   logic       sda_r;
   logic       scl_nxt;
   logic       sda_nxt;
   bvs_pkg::bvs_i2c_state_t st_r;
   logic [7:0] sh_r;
   logic [7:0] rd_r;
   logic [7:0] rd_val;
   logic [3:0] cnt_r;
   logic [7:0] ptr_r;
   logic       rw_r;
   logic       rack_r;
   logic       wr_stb_r;
   logic [7:0] wr_dat_r;
   logic [7:0] wr_ptr_r;
   logic [7:0] cpu_base_r;
   logic [7:0] soc_base_r;
   logic [7:0] half2_base_r;
   logic [7:0] rail_ctrl_r;
   logic [7:0] trk_volt_r;
   logic [7:0] trk_ctrl_r;
   logic [7:0] dev_cfg_r;
   logic [7:0] cpu_tgt_r;
   logic [7:0] soc_tgt_r;
   logic       cpu_on_d_r;
   logic       soc_on_d_r;
   logic       start_ev;
   logic       stop_ev;
   logic       scl_rise;
   logic       scl_fall;
   bvs_pkg::bvs_frame_t cpu_frame;
   bvs_pkg::bvs_frame_t soc_frame;

   // saturating add of base code and offset steps
   function automatic logic [7:0] sat_add(input logic [7:0] base, input logic [5:0] ofs);
      logic [8:0] sum;
      sum = {1'b0, base} + {3'h0, ofs};
      sat_add = sum[8] ? 8'hff : sum[7:0];
   endfunction

   // register read mux
   function automatic logic [7:0] reg_read(input logic [7:0] a);
      case (a)
         `BVS_OFS_CPU_BASE:   reg_read = cpu_base_r;
         `BVS_OFS_SOC_BASE:   reg_read = soc_base_r;
         `BVS_OFS_RAIL_CTRL:  reg_read = rail_ctrl_r;
         `BVS_OFS_CPU_TARGET: reg_read = cpu_tgt_r;
         `BVS_OFS_SOC_TARGET: reg_read = soc_tgt_r;
         `BVS_OFS_HALF2_BASE: reg_read = half2_base_r;
         `BVS_OFS_TRK_VOLT:   reg_read = trk_volt_r;
         `BVS_OFS_TRK_CTRL:   reg_read = trk_ctrl_r;
         `BVS_OFS_DEV_CFG:    reg_read = dev_cfg_r;
         default:             reg_read = 8'h00;
      endcase
   endfunction

   // register contents at the read pointer, for the next outgoing byte
   always_comb
   begin
      rd_val = reg_read(ptr_r);
   end

   // pin synchronisers for the i2c lines
   always_ff @(posedge i_clk_sys)
   begin
      if (i_reset)
      begin
         scl_sync_r <= 3'h7;
         sda_sync_r <= 3'h7;
         scl_r      <= 1'b1;
         sda_r      <= 1'b1;
      end
      else
      begin
         scl_sync_r <= {scl_sync_r[1:0], i_scl};
         sda_sync_r <= {sda_sync_r[1:0], i_sda};
         scl_r      <= scl_nxt;
         sda_r      <= sda_nxt;
      end
   end

   // filtered levels and bus events
   assign scl_nxt  = (scl_sync_r[1] == scl_sync_r[2]) ? scl_sync_r[2] : scl_r;
   assign sda_nxt  = (sda_sync_r[1] == sda_sync_r[2]) ? sda_sync_r[2] : sda_r;
   assign scl_rise = scl_nxt & ~scl_r;
   assign scl_fall = ~scl_nxt & scl_r;
   assign start_ev = scl_r & scl_nxt & sda_r & ~sda_nxt;
   assign stop_ev  = scl_r & scl_nxt & ~sda_r & sda_nxt;

   // i2c target engine, 7-bit address, byte pointer auto-increment [R14]
   always_ff @(posedge i_clk_sys)
   begin
      if (i_reset)
      begin
         st_r     <= bvs_pkg::BVS_I_IDLE;
         sh_r     <= 8'h00;
         rd_r     <= 8'h00;
         cnt_r    <= 4'h0;
         ptr_r    <= 8'h00;
         rw_r     <= 1'b0;
         rack_r   <= 1'b1;
         o_sda_oe <= 1'b0;
         wr_stb_r <= 1'b0;
         wr_dat_r <= 8'h00;
         wr_ptr_r <= 8'h00;
      end
      else
      begin
         wr_stb_r <= 1'b0;
         if (start_ev)
         begin
            st_r     <= bvs_pkg::BVS_I_ADDR;
            cnt_r    <= 4'h0;
            o_sda_oe <= 1'b0;
         end
         else if (stop_ev)
         begin
            st_r     <= bvs_pkg::BVS_I_IDLE;
            o_sda_oe <= 1'b0;
         end
         else if (scl_rise)
         begin
            if (st_r == bvs_pkg::BVS_I_ADDR || st_r == bvs_pkg::BVS_I_REG || st_r == bvs_pkg::BVS_I_WRITE)
            begin
               sh_r  <= {sh_r[6:0], sda_r};
               cnt_r <= cnt_r + 4'h1;
            end
            else if (st_r == bvs_pkg::BVS_I_RD_ACK)
               rack_r <= sda_r;
         end
         else if (scl_fall)
         begin
            case (st_r)
               bvs_pkg::BVS_I_ADDR:
                  if (cnt_r == 4'h8)
                  begin
                     if (sh_r[7:1] == DEV_ADDR)
                     begin
                        st_r     <= bvs_pkg::BVS_I_ACK_ADR;
                        rw_r     <= sh_r[0];
                        o_sda_oe <= 1'b1;
                     end
                     else
                        st_r <= bvs_pkg::BVS_I_IDLE;
                  end
               bvs_pkg::BVS_I_ACK_ADR:
               begin
                  cnt_r <= 4'h0;
                  if (rw_r)
                  begin
                     rd_r     <= rd_val;
                     o_sda_oe <= ~rd_val[7];
                     ptr_r    <= ptr_r + 8'h01;
                     cnt_r    <= 4'h1;
                     st_r     <= bvs_pkg::BVS_I_READ;
                  end
                  else
                  begin
                     o_sda_oe <= 1'b0;
                     st_r     <= bvs_pkg::BVS_I_REG;
                  end
               end
               bvs_pkg::BVS_I_REG:
                  if (cnt_r == 4'h8)
                  begin
                     ptr_r    <= sh_r;
                     o_sda_oe <= 1'b1;
                     st_r     <= bvs_pkg::BVS_I_ACK_REG;
                  end
               bvs_pkg::BVS_I_WRITE:
                  if (cnt_r == 4'h8)
                  begin
                     wr_stb_r <= 1'b1;
                     wr_dat_r <= sh_r;
                     wr_ptr_r <= ptr_r;
                     ptr_r    <= ptr_r + 8'h01;
                     o_sda_oe <= 1'b1;
                     st_r     <= bvs_pkg::BVS_I_ACK_WR;
                  end
               bvs_pkg::BVS_I_ACK_REG, bvs_pkg::BVS_I_ACK_WR:
               begin
                  o_sda_oe <= 1'b0;
                  cnt_r    <= 4'h0;
                  st_r     <= bvs_pkg::BVS_I_WRITE;
               end
               bvs_pkg::BVS_I_READ:
                  if (cnt_r == 4'h8)
                  begin
                     o_sda_oe <= 1'b0;
                     st_r     <= bvs_pkg::BVS_I_RD_ACK;
                  end
                  else
                  begin
                     o_sda_oe <= ~rd_r[3'd7 - cnt_r[2:0]];
                     cnt_r    <= cnt_r + 4'h1;
                  end
               bvs_pkg::BVS_I_RD_ACK:
                  if (!rack_r)
                  begin
                     rd_r     <= rd_val;
                     o_sda_oe <= ~rd_val[7];
                     ptr_r    <= ptr_r + 8'h01;
                     cnt_r    <= 4'h1;
                     st_r     <= bvs_pkg::BVS_I_READ;
                  end
                  else
                     st_r <= bvs_pkg::BVS_I_IDLE;
               default:
                  st_r <= bvs_pkg::BVS_I_IDLE;
            endcase
         end
      end
   end

   assign o_sda_out = 1'b0;

   // writable registers; rail turn-off clears its scaling enable
   always_ff @(posedge i_clk_sys)
   begin
      if (i_reset)
      begin
         cpu_base_r   <= `BVS_RST_BYTE;
         soc_base_r   <= `BVS_RST_BYTE;
         half2_base_r <= `BVS_RST_BYTE;
         rail_ctrl_r  <= `BVS_RST_BYTE;
         trk_volt_r   <= `BVS_RST_BYTE;
         trk_ctrl_r   <= `BVS_RST_BYTE;
         dev_cfg_r    <= `BVS_RST_BYTE;
      end
      else
      begin
         if (wr_stb_r)
         begin
            case (wr_ptr_r)
               `BVS_OFS_CPU_BASE:   cpu_base_r   <= wr_dat_r; // [R2]
               `BVS_OFS_SOC_BASE:   soc_base_r   <= wr_dat_r; // [R2]
               `BVS_OFS_HALF2_BASE: half2_base_r <= wr_dat_r; // [R10]
               `BVS_OFS_RAIL_CTRL:  rail_ctrl_r  <= {2'h0, wr_dat_r[5:0]};
               `BVS_OFS_TRK_VOLT:   trk_volt_r   <= wr_dat_r; // [R13]
               `BVS_OFS_TRK_CTRL:   trk_ctrl_r   <= {7'h00, wr_dat_r[`BVS_TC_FOLLOW]};
               `BVS_OFS_DEV_CFG:    dev_cfg_r    <= {6'h00, wr_dat_r[1:0]}; // [R8]
               default:             ;
            endcase
         end
         if (cpu_on_d_r && !rail_ctrl_r[`BVS_RC_CPU_ON])
            rail_ctrl_r[`BVS_RC_CPU_SCALE] <= 1'b0; // [R7]
         if (soc_on_d_r && !rail_ctrl_r[`BVS_RC_SOC_ON])
            rail_ctrl_r[`BVS_RC_SOC_SCALE] <= 1'b0; // [R7]
      end
   end

   // rail enable history for off detection
   always_ff @(posedge i_clk_sys)
   begin
      if (i_reset)
      begin
         cpu_on_d_r <= 1'b0;
         soc_on_d_r <= 1'b0;
      end
      else
      begin
         cpu_on_d_r <= rail_ctrl_r[`BVS_RC_CPU_ON];
         soc_on_d_r <= rail_ctrl_r[`BVS_RC_SOC_ON];
      end
   end

   // frame decoders, held idle while scaling is disabled
   bvs_frame_decoder u_cpu_dec (
      .i_clk_sys  (i_clk_sys),
      .i_reset    (i_reset),
      .i_enable   (rail_ctrl_r[`BVS_RC_CPU_SCALE]), // [R15] [R10]
      .i_link_clk (i_cpu_scl_clk),
      .i_data     (i_cpu_scaling_serial_data),
      .o_frame    (cpu_frame)
   );

   bvs_frame_decoder u_soc_dec (
      .i_clk_sys  (i_clk_sys),
      .i_reset    (i_reset),
      .i_enable   (rail_ctrl_r[`BVS_RC_SOC_SCALE]), // [R15]
      .i_link_clk (i_soc_scl_clk),
      .i_data     (i_soc_scaling_serial_data),
      .o_frame    (soc_frame)
   );

   // targets: base plus offset at frame end, base alone when not scaling
   always_ff @(posedge i_clk_sys)
   begin
      if (i_reset)
      begin
         cpu_tgt_r <= `BVS_RST_BYTE;
         soc_tgt_r <= `BVS_RST_BYTE;
      end
      else
      begin
         if (!rail_ctrl_r[`BVS_RC_CPU_SCALE])
            cpu_tgt_r <= cpu_base_r; // [R15]
         else if (cpu_frame.done)
            cpu_tgt_r <= sat_add(cpu_base_r, cpu_frame.offset); // [R1] [R16]
         if (!rail_ctrl_r[`BVS_RC_SOC_SCALE])
            soc_tgt_r <= soc_base_r; // [R15]
         else if (soc_frame.done)
            soc_tgt_r <= sat_add(soc_base_r, soc_frame.offset); // [R1] [R16]
      end
   end

   // outputs and pin roles
   assign o_cpu_target   = cpu_tgt_r;
   assign o_soc_target   = soc_tgt_r;
   assign o_half2_target = half2_base_r; // register control only [R10]
   assign o_cpu_on       = rail_ctrl_r[`BVS_RC_CPU_ON];
   assign o_soc_on       = rail_ctrl_r[`BVS_RC_SOC_ON];
   assign o_half2_on     = dev_cfg_r[`BVS_CFG_SPLIT] & rail_ctrl_r[`BVS_RC_HALF2_ON]; // [R8]
   assign o_split        = dev_cfg_r[`BVS_CFG_SPLIT]; // [R8]
   assign o_pg_pin_out   = i_cpu_power_good;
   assign o_pg_pin_oe    = ~dev_cfg_r[`BVS_CFG_SPLIT]; // becomes feedback input [R9]
   assign o_ext_pin_out  = dev_cfg_r[`BVS_CFG_SPLIT] ? i_cpu_power_good : rail_ctrl_r[`BVS_RC_EXT_EN]; // [R9]
   assign o_trk_follow   = trk_ctrl_r[`BVS_TC_FOLLOW]; // [R11]
   assign o_trk_target   = !trk_ctrl_r[`BVS_TC_FOLLOW] ? trk_volt_r : // [R13]
                           (dev_cfg_r[`BVS_CFG_TRK_SRC] ? cpu_tgt_r : soc_tgt_r); // [R12]
endmodule

// ==== bvs_chk.sv ====
`timescale 1ns/10ps
module bvs_chk (
   input wire logic       i_clk_sys,        // system clock
   input wire logic       i_reset,          // sync reset
   input wire logic       i_scl,            // i2c clock pin
   input wire logic       i_cpu_scl_clk,    // cpu link clock
   input wire logic       i_soc_scl_clk,    // soc link clock
   input wire logic       i_cpu_power_good, // cpu power good
   input wire logic       o_sda_oe,         // sda pull low
   input wire logic [7:0] o_cpu_target,     // cpu target
   input wire logic [7:0] o_soc_target,     // soc target
   input wire logic       o_half2_on,       // second half on
   input wire logic       o_split,          // split mode
   input wire logic       o_pg_pin_out,     // pg pin value
   input wire logic       o_pg_pin_oe,      // pg pin drive
   input wire logic       o_ext_pin_out,    // ext pin value
   input wire logic       o_trk_follow,     // tracking follows
   input wire logic [7:0] o_trk_target      // tracking code
);
   logic       scl_q_r;
   logic       cc_q_r;
   logic       sc_q_r;
   logic [4:0] scl_age_r;
   logic [4:0] cc_age_r;
   logic [4:0] sc_age_r;
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_reset);
   // cycles since last bus clock fall or link clock rise
   always_ff @(posedge i_clk_sys)
   begin
      scl_q_r   <= i_scl;
      cc_q_r    <= i_cpu_scl_clk;
      sc_q_r    <= i_soc_scl_clk;
      scl_age_r <= (i_reset || (scl_q_r && !i_scl)) ? 5'h00 : scl_age_r + 5'(scl_age_r != 5'h1f);
      cc_age_r  <= (i_reset || (!cc_q_r && i_cpu_scl_clk)) ? 5'h00 : cc_age_r + 5'(cc_age_r != 5'h1f);
      sc_age_r  <= (i_reset || (!sc_q_r && i_soc_scl_clk)) ? 5'h00 : sc_age_r + 5'(sc_age_r != 5'h1f);
   end
   a_pg_value: assert property (o_pg_pin_out == i_cpu_power_good)
      else $error("pg pin value wrong");
   a_split_pg_in: assert property (o_split |-> !o_pg_pin_oe)
      else $error("pg pin driven in split");
   a_unsplit_pg_out: assert property (!o_split |-> o_pg_pin_oe)
      else $error("pg pin idle when unsplit");
   a_split_pg_two: assert property (o_split |-> o_ext_pin_out == i_cpu_power_good)
      else $error("second pg value wrong");
   a_half2_split: assert property (o_half2_on |-> o_split)
      else $error("second half on unsplit");
   a_trk_follow: assert property ((o_trk_follow && $stable(o_cpu_target) && $stable(o_soc_target))[*3]
      |-> (o_trk_target == o_cpu_target || o_trk_target == o_soc_target))
      else $error("tracking not following");
   a_cpu_tgt_cause: assert property ($changed(o_cpu_target) |-> (cc_age_r < 5'h10 || scl_age_r < 5'h1f))
      else $error("cpu target moved without cause");
   a_soc_tgt_cause: assert property ($changed(o_soc_target) |-> (sc_age_r < 5'h10 || scl_age_r < 5'h1f))
      else $error("soc target moved without cause");
   a_sda_scl_low: assert property ($changed(o_sda_oe) |-> !i_scl)
      else $error("sda moved while scl high");
   c_cpu_tgt: cover property ($changed(o_cpu_target));
   c_half2: cover property (o_split && o_half2_on);
   c_ack: cover property ($rose(o_sda_oe));
endmodule
bind bvs_scaling_control bvs_chk chk (.*);

// ==== bvs_ap_model.sv ====
`timescale 1ns/10ps
module bvs_ap_model (
   output logic o_clk,  // link clock, parked low
   output logic o_data  // link data
);
   initial
   begin
      o_clk = 1'b0;
      o_data = 1'b0;
   end
   // data rise opens frame, then 32 clock periods of n high samples
   task automatic send_frame(input int n, input int slow);
      int lo;
      int hi;
      o_data = 1'b1;
      #40;
      for (int i = 0; i < 32; i++)
      begin
         lo = 40 + int'($urandom_range(45)) + slow;
         hi = 40 + int'($urandom_range(45)) + slow;
         o_data = (i < n);
         #(lo) o_clk = 1'b1;
         #(hi) o_clk = 1'b0;
      end
      o_data = 1'b0;
      #100;
   endtask
endmodule

// ==== bvs_scaling_control_test.sv ====
`timescale 1ns/10ps
module bvs_scaling_control_test;
   localparam logic [6:0] DA = 7'h2a; // arbitrary bus address
   logic       clk, rst, scl, sda_lo, pg, sda_out, sda_oe, cc, cd, sc, sd;
   logic       cpu_on, soc_on, h2_on, split, pg_out, pg_oe, ext_out, trk_f;
   logic [7:0] cpu_t, soc_t, h2_t, trk_t;
   logic [7:0] m [256];
   int         err_count, checked, cpu_n, soc_n, cyc;
   wire        sda_ln = !(sda_lo || sda_oe);
   bvs_scaling_control #(.DEV_ADDR(DA)) uut (.i_clk_sys(clk), .i_reset(rst), .i_scl(scl), .i_sda(sda_ln),
      .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_cpu_scl_clk(cc), .i_cpu_scaling_serial_data(cd),
      .i_soc_scl_clk(sc), .i_soc_scaling_serial_data(sd), .i_cpu_power_good(pg), .o_cpu_target(cpu_t),
      .o_soc_target(soc_t), .o_half2_target(h2_t), .o_cpu_on(cpu_on), .o_soc_on(soc_on), .o_half2_on(h2_on),
      .o_split(split), .o_pg_pin_out(pg_out), .o_pg_pin_oe(pg_oe), .o_ext_pin_out(ext_out),
      .o_trk_follow(trk_f), .o_trk_target(trk_t));
   bvs_ap_model ap_c (.o_clk(cc), .o_data(cd));
   bvs_ap_model ap_s (.o_clk(sc), .o_data(sd));
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // hang guard
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 90000)
      begin
         err_count++;
         stop_test();
      end
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      checked++;
      if (g !== e)
      begin
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
         err_count++;
      end
   endtask
   // model: saturating target, expected read, write side effects
   function automatic logic [7:0] sat(input logic [7:0] b, input int n);
      return (int'(b) + n > 255) ? 8'hff : 8'(int'(b) + n);
   endfunction
   function automatic logic [7:0] tg(input int c);
      if (m[8'h12][3 - c])
         return sat(m[8'h11 - c], c ? cpu_n : soc_n);
      return m[8'h11 - c];
   endfunction
   function automatic logic [7:0] ex(input logic [7:0] a);
      case (a)
         8'h10, 8'h11, 8'h15, 8'h18: return m[a];
         8'h12: return m[a] & 8'h3f;
         8'h13: return tg(1);
         8'h14: return tg(0);
         8'h19: return m[a] & 8'h01;
         8'h7f: return m[a] & 8'h03;
         default: return 8'h00;
      endcase
   endfunction
   function automatic void mw(input logic [7:0] a, input logic [7:0] d);
      if (a == 8'h12 && m[a][0] && !d[0])
         d[2] = 1'b0;
      if (a == 8'h12 && m[a][1] && !d[1])
         d[3] = 1'b0;
      m[a] = d;
   endfunction
   // i2c bit, byte, start and stop at about 3.3 MHz
   task automatic bit_x(input logic b, output logic r);
      sda_lo <= !b;
      tick(20);
      scl <= 1'b1;
      tick(20);
      r = sda_ln;
      scl <= 1'b0;
      tick(20);
   endtask
   task automatic byte_x(input logic [7:0] d, input logic a, output logic [7:0] r, output logic k);
      logic b;
      for (int i = 7; i >= 0; i--)
      begin
         bit_x(d[i], b);
         r[i] = b;
      end
      bit_x(a, b);
      k = !b;
   endtask
   task automatic i2c_start();
      sda_lo <= 1'b0;
      scl <= 1'b1;
      tick(20);
      sda_lo <= 1'b1;
      tick(20);
      scl <= 1'b0;
      tick(20);
   endtask
   task automatic i2c_stop();
      sda_lo <= 1'b1;
      tick(20);
      scl <= 1'b1;
      tick(20);
      sda_lo <= 1'b0;
      tick(20);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] q[$]);
      logic [7:0] r;
      logic k;
      i2c_start();
      byte_x({DA, 1'b0}, 1'b1, r, k);
      byte_x(a, 1'b1, r, k);
      foreach (q[i])
      begin
         byte_x(q[i], 1'b1, r, k);
         chk({7'h0, k}, 8'h01);
         mw(8'(a + i), q[i]);
      end
      i2c_stop();
   endtask
   task automatic rd(input logic [7:0] a, input int n);
      logic [7:0] r;
      logic k;
      i2c_start();
      byte_x({DA, 1'b0}, 1'b1, r, k);
      byte_x(a, 1'b1, r, k);
      i2c_start();
      byte_x({DA, 1'b1}, 1'b1, r, k);
      for (int i = 0; i < n; i++)
      begin
         byte_x(8'hff, i == n - 1, r, k);
         chk(r, ex(8'(a + i)));
      end
      i2c_stop();
   endtask
   task automatic pins();
      chk({4'h0, cpu_on, soc_on, h2_on, split}, {4'h0, m[8'h12][0], m[8'h12][1], m[8'h7f][0] & m[8'h12][4], m[8'h7f][0]});
      chk({5'h0, pg_oe, ext_out, pg_out}, {5'h0, !m[8'h7f][0], m[8'h7f][0] ? pg : m[8'h12][5], pg});
      chk(h2_t, m[8'h15]);
   endtask
   // both rails send a frame, then targets are compared
   task automatic frame(input int nc, input int ns, input int slow);
      fork
         ap_c.send_frame(nc, slow);
         ap_s.send_frame(ns, slow);
      join
      tick(12);
      if (m[8'h12][2])
         cpu_n = nc;
      if (m[8'h12][3])
         soc_n = ns;
      chk(cpu_t, tg(1));
      chk(soc_t, tg(0));
      chk(trk_t, m[8'h19][0] ? tg(int'(m[8'h7f][1])) : m[8'h18]);
      chk({6'h0, sda_out, trk_f}, {7'h0, m[8'h19][0]});
   endtask
   initial
   begin
      logic [7:0] r;
      logic k;
      int nq[$];
      void'($urandom(82));
      {rst, scl, sda_lo, pg, cyc, err_count, checked, cpu_n, soc_n} = {4'b1100, 160'h0};
      foreach (m[i])
         m[i] = 8'h00;
      tick(16);
      rst <= 1'b0;
      tick(4);
      rd(8'h10, 10);
      rd(8'h7f, 1);
      pins();
      $display("test reset values done");
      wr(8'h10, '{8'($urandom_range(200)), 8'($urandom_range(200)), 8'h33, 8'h5a, 8'ha5, 8'($urandom), 8'h77,
         8'h0f, 8'($urandom), 8'h00});
      rd(8'h10, 10);
      wr(8'h7f, '{8'hfc});
      rd(8'h7f, 1);
      i2c_start();
      byte_x({~DA, 1'b0}, 1'b1, r, k);
      i2c_stop();
      chk({7'h0, k}, 8'h00);
      $display("test register access done");
      wr(8'h12, '{8'h3f});
      nq = '{0, 32, $urandom_range(31, 1)};
      foreach (nq[i])
         frame(nq[i], 32 - nq[i], i * 40);
      wr(8'h10, '{8'hf0});
      frame(32, 5, 0);
      rd(8'h13, 2);
      $display("test scaling frames done");
      wr(8'h12, '{8'h37});
      frame(5, 20, 0);
      $display("test scaling disabled done");
      wr(8'h12, '{8'h36});
      rd(8'h12, 1);
      pins();
      frame(9, 9, 0);
      wr(8'h12, '{8'h3f});
      frame(3, 4, 0);
      $display("test auto clear done");
      wr(8'h7f, '{8'h01});
      wr(8'h15, '{8'($urandom)});
      for (int i = 0; i < 2; i++)
      begin
         pg <= 1'(i);
         tick(3);
         pins();
      end
      frame(12, 3, 0);
      wr(8'h12, '{8'h2f});
      pins();
      $display("test split done");
      for (int s = 0; s < 3; s++)
      begin
         wr(8'h7f, '{8'(s % 2 * 2)});
         wr(8'h19, '{8'(s < 2)});
         frame($urandom_range(32), $urandom_range(32), 0);
      end
      $display("test tracking done");
      stop_test();
   end
endmodule
